// ==== cdap_pkg.sv ====
// Package for the cache debug access port: transfer decode, field positions and reset values.
// Assumes the core presents one coprocessor register transfer per cycle on the core clock.
`default_nettype none

package cdap_pkg;

	// Transfer selector values that this port answers to.
	localparam logic [3:0] SYSTEM_COPROC_NUMBER = 4'hF;
	localparam logic [2:0] DEBUG_OPC1           = 3'h3;
	localparam logic [3:0] DEBUG_CRN            = 4'hF;
	localparam logic [2:0] DEBUG_OPC2           = 3'h0;

	// Secondary register numbers, one per debug operation.
	typedef enum logic [3:0] {
		CDAP_OP_POINTER = 4'h0,
		CDAP_OP_ITAG    = 4'h1,
		CDAP_OP_DTAG    = 4'h2,
		CDAP_OP_IDATA   = 4'h3,
		CDAP_OP_DDATA   = 4'h4
	} cdap_op_t;

	// Probe pointer field positions.
	localparam int PTR_SET_HI  = 31;
	localparam int PTR_SET_LO  = 30;
	localparam int PTR_IDX_LO  = 5;
	localparam int PTR_WORD_HI = 4;
	localparam int PTR_WORD_LO = 2;

	// Tag transfer word field positions.
	localparam int TAG_VALID_BIT = 4;
	localparam int TAG_DIRTY_HI  = 3;
	localparam int TAG_DIRTY_LO  = 2;
	localparam int TAG_WAY_HI    = 1;
	localparam int TAG_WAY_LO    = 0;

	// Geometry constants.
	localparam int LINE_BYTES     = 32;
	localparam int WORDS_PER_LINE = 8;
	localparam int ADDR_BITS      = 32;

	// Values after reset.
	localparam logic [1:0]  PTR_SET_RESET  = 2'h0;
	localparam logic [2:0]  PTR_WORD_RESET = 3'h0;
	localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

	// One coprocessor register transfer from the core.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  cp_num;
		logic [2:0]  opc1;
		logic [3:0]  crn;
		logic [3:0]  crm;
		logic [2:0]  opc2;
		logic [31:0] wdata;
	} cdap_req_t;

endpackage

`default_nettype wire

// ==== cdap_tag_array.sv ====
// Tag store for one cache: tag address and dirty flags per way and line, valid flags in flip-flops.
// Assumes the caller supplies an in-range way; read is combinational, write lands on the clock edge.
`timescale 1ns/1ps
`default_nettype none

module cdap_tag_array #(
	parameter int WAYS  = 4,
	parameter int IDX_W = 5,
	parameter int TAG_W = 22
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             wr_en,
	input  wire logic [1:0]       way,
	input  wire logic [IDX_W-1:0] idx,
	input  wire logic [TAG_W-1:0] wr_tag,
	input  wire logic             wr_valid,
	input  wire logic [1:0]       wr_dirty,
	output logic      [TAG_W-1:0] rd_tag,
	output logic                  rd_valid,
	output logic      [1:0]       rd_dirty
);

	localparam int WAY_BITS = $clog2(WAYS);
	localparam int AW       = IDX_W + WAY_BITS;
	localparam int DEPTH    = WAYS << IDX_W;

	// Only one-, two- and four-way stores fit the two-bit way input.
	generate
		if (!(WAYS == 1 || WAYS == 2 || WAYS == 4) || IDX_W < 1 || TAG_W < 1) begin : g_bad_param
			$error("cdap_tag_array: unsupported geometry");
		end
	endgenerate

	logic [TAG_W+1:0] tag_mem [DEPTH];
	logic [DEPTH-1:0] valid_r;
	logic [AW-1:0]    addr;

	// Direct-mapped stores have no way bits in the address.
	generate
		if (WAY_BITS == 0) begin : g_dm
			assign addr = idx;
		end else begin : g_sa
			assign addr = {way[WAY_BITS-1:0], idx};
		end
	endgenerate

	// Tag and dirty flags carry no reset; only valid flags decide whether an entry counts.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			tag_mem[addr] <= {wr_tag, wr_dirty};
		end
	end

	// Valid flags sit in flip-flops so reset can clear all of them at once.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_r <= '0;
		end else if (wr_en) begin
			valid_r[addr] <= wr_valid;
		end
	end

	assign rd_tag   = tag_mem[addr][TAG_W+1:2];
	assign rd_dirty = tag_mem[addr][1:0];
	assign rd_valid = valid_r[addr];

endmodule

`default_nettype wire

// ==== cdap_data_array.sv ====
// Data store for one cache: eight words per line for each way and line index.
// Assumes the caller supplies an in-range way; read is combinational, write lands on the clock edge.
`timescale 1ns/1ps
`default_nettype none

module cdap_data_array #(
	parameter int WAYS  = 4,
	parameter int IDX_W = 5
) (
	input  wire logic             clk,
	input  wire logic             wr_en,
	input  wire logic [1:0]       way,
	input  wire logic [IDX_W-1:0] idx,
	input  wire logic [2:0]       word,
	input  wire logic [31:0]      wdata,
	output logic      [31:0]      rdata
);

	localparam int WAY_BITS = $clog2(WAYS);
	localparam int AW       = IDX_W + WAY_BITS + 3;
	localparam int DEPTH    = (WAYS << IDX_W) * cdap_pkg::WORDS_PER_LINE;

	// Only one-, two- and four-way stores fit the two-bit way input.
	generate
		if (!(WAYS == 1 || WAYS == 2 || WAYS == 4) || IDX_W < 1) begin : g_bad_param
			$error("cdap_data_array: unsupported geometry");
		end
	endgenerate

	logic [31:0]   data_mem [DEPTH];
	logic [AW-1:0] addr;

	// Word address is way, line, then word within the line.
	generate
		if (WAY_BITS == 0) begin : g_dm
			assign addr = {idx, word};
		end else begin : g_sa
			assign addr = {way[WAY_BITS-1:0], idx, word};
		end
	endgenerate

	// Plain single-port store; contents are unknown until written.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			data_mem[addr] <= wdata;
		end
	end

	assign rdata = data_mem[addr];

endmodule

`default_nettype wire

// ==== cdap_top.sv ====
// Cache debug access port: coprocessor transfers reach the probe pointer and the cache tag and data stores.
// Assumes the core drives the transfer struct from logic on CLK, so it is used without synchronisers.
// Transfers outside the debug selector group see CP_ACCEPT low and are left for other units to answer.
// Array contents other than the valid flags carry no reset value and read as unknown until written.
// Read answers come one edge after the transfer; writes take effect at the edge that takes them.
`timescale 1ns/1ps
`default_nettype none

module cdap_top #(
	parameter int CACHE_KB = 4,
	parameter int WAYS     = 4
) (
	input  wire logic               CLK,
	input  wire logic               ARST_N,
	input  wire cdap_pkg::cdap_req_t CP_REQ,
	output logic                    CP_ACCEPT,
	output logic                    CP_RVALID,
	output logic [31:0]             CP_RDATA
);

	// Pointer and tag word share one layout: index from bit 5 up to N_HI, tag or reserved bits above it.
	// RSV_W counts the reserved pointer bits between the index and the set field.
	// Lines per way follow size and associativity, which fixes the index width.
	localparam int LINES = (CACHE_KB * 1024) / (WAYS * cdap_pkg::LINE_BYTES);
	localparam int IDX_W = $clog2(LINES);
	localparam int N_HI  = cdap_pkg::PTR_IDX_LO + IDX_W - 1;
	localparam int TAG_W = cdap_pkg::ADDR_BITS - 1 - N_HI;
	localparam int RSV_W = cdap_pkg::PTR_SET_LO - 1 - N_HI;
	localparam logic [1:0] WAY_MASK = 2'(WAYS - 1);

	// Refuse geometries that the field layout cannot carry.
	generate
		if (!(WAYS == 1 || WAYS == 2 || WAYS == 4)) begin : g_bad_ways
			$error("cdap_top: WAYS must be 1, 2 or 4");
		end
		if (CACHE_KB < 4 || CACHE_KB > 1024 || (CACHE_KB & (CACHE_KB - 1)) != 0) begin : g_bad_size
			$error("cdap_top: CACHE_KB must be a power of two from 4 to 1024");
		end
		// The index must end below the set field, or the two would share pointer bits.
		if (N_HI + 1 > cdap_pkg::PTR_SET_LO) begin : g_bad_layout
			$error("cdap_top: index field overlaps the set field");
		end
		// The three-bit word field reaches exactly eight words of four bytes.
		if (cdap_pkg::LINE_BYTES != 4 * cdap_pkg::WORDS_PER_LINE || cdap_pkg::WORDS_PER_LINE != 8) begin : g_bad_line
			$error("cdap_top: line length does not match the word field");
		end
	endgenerate

	// Reset release passes two flip-flops so that every process leaves reset on the same edge.
	// Assertion stays asynchronous, so the valid flags clear even while the clock is stopped.
	// The cost is two edges after release in which a transfer is shown accepted, but only its tag and data array writes land (valid flags stay cleared).
	// The core must therefore hold its first request until the third edge after release.
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Transfer decode: only the debug selector group is taken; anything else is left for other units.
	// A transfer with any field outside the group is refused whole, so it changes no state here.
	logic     sel_hit;
	logic     op_known;
	cdap_pkg::cdap_op_t op;

	assign sel_hit = CP_REQ.valid
		&& (CP_REQ.cp_num == cdap_pkg::SYSTEM_COPROC_NUMBER)
		&& (CP_REQ.opc1 == cdap_pkg::DEBUG_OPC1)
		&& (CP_REQ.crn == cdap_pkg::DEBUG_CRN)
		&& (CP_REQ.opc2 == cdap_pkg::DEBUG_OPC2);

	// Map the secondary register onto an operation; unknown numbers are not accepted.
	// Selector numbers above four name no debug operation and fall to the default branch.
	always_comb begin
		op       = cdap_pkg::CDAP_OP_POINTER;
		op_known = 1'b1;
		case (CP_REQ.crm)
			cdap_pkg::CDAP_OP_POINTER: op = cdap_pkg::CDAP_OP_POINTER;
			cdap_pkg::CDAP_OP_ITAG:    op = cdap_pkg::CDAP_OP_ITAG;
			cdap_pkg::CDAP_OP_DTAG:    op = cdap_pkg::CDAP_OP_DTAG;
			cdap_pkg::CDAP_OP_IDATA:   op = cdap_pkg::CDAP_OP_IDATA;
			cdap_pkg::CDAP_OP_DDATA:   op = cdap_pkg::CDAP_OP_DDATA;
			default:                   op_known = 1'b0;
		endcase
	end

	// Reads and writes share one decode; the direction bit alone picks between them.
	// CP_ACCEPT is combinational so the core learns in the same cycle whether this block owns the transfer.
	logic take;
	logic take_wr;
	logic take_rd;

	assign take      = sel_hit && op_known;
	assign take_wr   = take && CP_REQ.write;
	assign take_rd   = take && !CP_REQ.write;
	assign CP_ACCEPT = take;

	// Holding the pointer across array operations lets a debugger walk a line by rewriting only the word field.
	// Probe pointer: only set, index and word are stored; reserved bits are not kept.
	logic [1:0]       ptr_set_r;
	logic [IDX_W-1:0] ptr_idx_r;
	logic [2:0]       ptr_word_r;

	// Reset gives a known pointer, though software must still load it first.
	// The reset value of zero is a choice of this block, not a guarantee software may rely on.
	always_ff @(posedge CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ptr_set_r  <= cdap_pkg::PTR_SET_RESET;
			ptr_idx_r  <= '0;
			ptr_word_r <= cdap_pkg::PTR_WORD_RESET;
		end else if (take_wr && op == cdap_pkg::CDAP_OP_POINTER) begin
			ptr_set_r  <= CP_REQ.wdata[cdap_pkg::PTR_SET_HI:cdap_pkg::PTR_SET_LO];
			ptr_idx_r  <= CP_REQ.wdata[N_HI:cdap_pkg::PTR_IDX_LO];
			ptr_word_r <= CP_REQ.wdata[cdap_pkg::PTR_WORD_HI:cdap_pkg::PTR_WORD_LO];
		end
	end

	// Ways beyond the implemented count fold onto the ones that exist.
	// A two-way store reads only bit 30 of the set field and a direct-mapped one ignores it.
	logic [1:0] way_eff;

	assign way_eff = ptr_set_r & WAY_MASK;

	// Fields of an incoming tag word; index and way bits are not used, the pointer picks the entry.
	// A tag entry has no room for them, so a read returns the pointer's index and way instead.
	logic [TAG_W-1:0] wr_tag;
	logic             wr_valid;
	logic [1:0]       wr_dirty;

	assign wr_tag   = CP_REQ.wdata[cdap_pkg::ADDR_BITS-1:N_HI+1];
	assign wr_valid = CP_REQ.wdata[cdap_pkg::TAG_VALID_BIT];
	assign wr_dirty = CP_REQ.wdata[cdap_pkg::TAG_DIRTY_HI:cdap_pkg::TAG_DIRTY_LO];

	// Per-store write strobes.
	// Writes need no answer: stores read combinationally, so the next transfer already sees the new contents.
	logic itag_we;
	logic dtag_we;
	logic idata_we;
	logic ddata_we;

	assign itag_we  = take_wr && (op == cdap_pkg::CDAP_OP_ITAG);
	assign dtag_we  = take_wr && (op == cdap_pkg::CDAP_OP_DTAG);
	assign idata_we = take_wr && (op == cdap_pkg::CDAP_OP_IDATA);
	assign ddata_we = take_wr && (op == cdap_pkg::CDAP_OP_DDATA);

	// Read-back values of the four stores.
	logic [TAG_W-1:0] itag_tag;
	logic             itag_valid;
	logic [1:0]       itag_dirty;
	logic [TAG_W-1:0] dtag_tag;
	logic             dtag_valid;
	logic [1:0]       dtag_dirty;
	logic [31:0]      idata_rd;
	logic [31:0]      ddata_rd;

	// Tag stores take no word address, so the word field cannot affect them.
	// Both caches share one pointer, so an operation on one never disturbs the other's contents.
	cdap_tag_array #(
		.WAYS  (WAYS),
		.IDX_W (IDX_W),
		.TAG_W (TAG_W)
	) u_itag (
		.clk      (CLK),
		.rst_n    (rst_n_r),
		.wr_en    (itag_we),
		.way      (way_eff),
		.idx      (ptr_idx_r),
		.wr_tag   (wr_tag),
		.wr_valid (wr_valid),
		.wr_dirty (wr_dirty),
		.rd_tag   (itag_tag),
		.rd_valid (itag_valid),
		.rd_dirty (itag_dirty)
	);

	// Data tag store, with the same layout as the instruction one.
	cdap_tag_array #(
		.WAYS  (WAYS),
		.IDX_W (IDX_W),
		.TAG_W (TAG_W)
	) u_dtag (
		.clk      (CLK),
		.rst_n    (rst_n_r),
		.wr_en    (dtag_we),
		.way      (way_eff),
		.idx      (ptr_idx_r),
		.wr_tag   (wr_tag),
		.wr_valid (wr_valid),
		.wr_dirty (wr_dirty),
		.rd_tag   (dtag_tag),
		.rd_valid (dtag_valid),
		.rd_dirty (dtag_dirty)
	);

	// Instruction word store, addressed down to the word within the line.
	cdap_data_array #(
		.WAYS  (WAYS),
		.IDX_W (IDX_W)
	) u_idata (
		.clk   (CLK),
		.wr_en (idata_we),
		.way   (way_eff),
		.idx   (ptr_idx_r),
		.word  (ptr_word_r),
		.wdata (CP_REQ.wdata),
		.rdata (idata_rd)
	);

	// Data word store, addressed the same way.
	cdap_data_array #(
		.WAYS  (WAYS),
		.IDX_W (IDX_W)
	) u_ddata (
		.clk   (CLK),
		.wr_en (ddata_we),
		.way   (way_eff),
		.idx   (ptr_idx_r),
		.word  (ptr_word_r),
		.wdata (CP_REQ.wdata),
		.rdata (ddata_rd)
	);

	// Assemble the read word for the selected operation; reserved pointer bits read as zero.
	// Data words are returned unmasked; a word never written since power-up reads as unknown.
	logic [31:0] rd_word;

	always_comb begin
		rd_word = cdap_pkg::RDATA_RESET;
		case (op)
			cdap_pkg::CDAP_OP_POINTER: begin
				rd_word = {ptr_set_r, {RSV_W{1'b0}}, ptr_idx_r, ptr_word_r, 2'h0};
			end
			cdap_pkg::CDAP_OP_ITAG: begin
				rd_word = {itag_tag, ptr_idx_r, itag_valid, itag_dirty, way_eff};
			end
			cdap_pkg::CDAP_OP_DTAG: begin
				rd_word = {dtag_tag, ptr_idx_r, dtag_valid, dtag_dirty, way_eff};
			end
			cdap_pkg::CDAP_OP_IDATA: begin
				rd_word = idata_rd;
			end
			cdap_pkg::CDAP_OP_DDATA: begin
				rd_word = ddata_rd;
			end
			default: begin
				// Unreachable while op holds one of the five decoded values.
				rd_word = cdap_pkg::RDATA_RESET;
			end
		endcase
	end

	// Read answer is registered one edge after the transfer and holds until the next read.
	// Holding it lets the core take the answer in any later cycle without a second read.
	always_ff @(posedge CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			CP_RDATA <= cdap_pkg::RDATA_RESET;
		end else if (take_rd) begin
			CP_RDATA <= rd_word;
		end
	end

	// Answer strobe is a one-cycle pulse matching the registered data.
	// Writes raise no strobe, so the core never waits on one.
	always_ff @(posedge CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			CP_RVALID <= 1'b0;
		end else begin
			CP_RVALID <= take_rd;
		end
	end

endmodule

`default_nettype wire

// ==== cdap_monitor.sv ====
// Checker for the cache debug access port, bound to cdap_top.
// Assumes it sees only the top ports; ARST_N releases two edges before the port answers.
`timescale 1ns/1ps
`default_nettype none

module cdap_monitor #(
	parameter int CACHE_KB = 4,
	parameter int WAYS     = 4
) (
	input wire logic                CLK,
	input wire logic                ARST_N,
	input wire cdap_pkg::cdap_req_t CP_REQ,
	input wire logic                CP_ACCEPT,
	input wire logic                CP_RVALID,
	input wire logic [31:0]         CP_RDATA
);
	localparam int          N        = 4 + $clog2(CACHE_KB * 32 / WAYS);
	localparam logic [31:0] LOW_ONES = (32'h1 << (N + 1)) - 32'h1;
	localparam logic [31:0] IDX_MASK = LOW_ONES & 32'hFFFF_FFE0;
	localparam logic [31:0] PTR_MASK = IDX_MASK | 32'hC000_001C;
	localparam logic [31:0] TAG_MASK = ~LOW_ONES | 32'h0000_001C;

	// Accepted reads and writes, and the selector, named once for the properties.
	wire logic       rd_acc = CP_ACCEPT && !CP_REQ.write;
	wire logic       wr_acc = CP_ACCEPT && CP_REQ.write;
	wire logic [3:0] crm    = CP_REQ.crm;

	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);

	accept_decode_a:
		assert property (CP_ACCEPT == (CP_REQ.valid && CP_REQ.cp_num == 4'hF && CP_REQ.opc1 == 3'h3
			&& CP_REQ.crn == 4'hF && CP_REQ.opc2 == 3'h0 && crm <= 4'h4)) else $error("accept decode wrong");
	read_answer_a:
		assert property (rd_acc |=> CP_RVALID) else $error("read not answered");
	answer_cause_a:
		assert property (CP_RVALID |-> $past(rd_acc)) else $error("answer without read");
	rdata_hold_a:
		assert property (!$past(rd_acc) |-> $stable(CP_RDATA)) else $error("read data moved");
	ptr_readback_a:
		assert property ($past(wr_acc && crm == 4'h0) && rd_acc && crm == 4'h0
			|=> CP_RDATA == ($past(CP_REQ.wdata, 2) & PTR_MASK)) else $error("pointer readback wrong");
	ptr_repeat_a:
		assert property ($past(rd_acc && crm == 4'h0) && rd_acc && crm == 4'h0 |=> $stable(CP_RDATA))
			else $error("pointer changed");
	tag_readback_a:
		assert property ($past(wr_acc && (crm == 4'h1 || crm == 4'h2)) && rd_acc && crm == $past(crm)
			|=> (CP_RDATA & TAG_MASK) == ($past(CP_REQ.wdata, 2) & TAG_MASK)) else $error("tag readback wrong");
	tag_place_a:
		assert property ($past(wr_acc && crm == 4'h0) && rd_acc && (crm == 4'h1 || crm == 4'h2)
			|=> (CP_RDATA & IDX_MASK) == ($past(CP_REQ.wdata, 2) & IDX_MASK)
			&& CP_RDATA[1:0] == (2'($past(CP_REQ.wdata, 2) >> 30) & 2'(WAYS - 1))) else $error("tag place wrong");
	data_readback_a:
		assert property ($past(wr_acc && crm > 4'h2) && rd_acc && crm == $past(crm)
			|=> CP_RDATA == $past(CP_REQ.wdata, 2)) else $error("data readback wrong");

	// Main scenarios: tag read, data write and a refused transfer.
	cover property (rd_acc && crm == 4'h1);
	cover property (wr_acc && crm == 4'h4);
	cover property (CP_REQ.valid && !CP_ACCEPT);
endmodule

bind cdap_top cdap_monitor #(.CACHE_KB(CACHE_KB), .WAYS(WAYS)) i_monitor (.CLK(CLK), .ARST_N(ARST_N),
	.CP_REQ(CP_REQ), .CP_ACCEPT(CP_ACCEPT), .CP_RVALID(CP_RVALID), .CP_RDATA(CP_RDATA));

`default_nettype wire

// ==== cdap_core_model.sv ====
// Model of the core that issues coprocessor register transfers.
// Assumes the bench calls xfer from one process; requests change only at falling edges.
`timescale 1ns/1ps
`default_nettype none

module cdap_core_model #(
	parameter logic [31:0] PTR_KEEP = 32'hC000_03FC
) (
	input  wire logic                clk,
	input  wire logic                cp_accept,
	output var cdap_pkg::cdap_req_t  cp_req
);
	cdap_pkg::cdap_req_t nxt;
	logic                pend = 1'b0;

	initial cp_req = '0;

	// One driver for the request; between transfers the fields toggle so stale values never pass.
	always @(negedge clk) begin
		cp_req <= pend ? nxt : {1'b0, ~cp_req[$bits(cp_req)-2:0]};
		pend   <= 1'b0;
	end

	// Hold one transfer for a cycle and take the accept at the rising edge that samples it.
	task automatic xfer(input cdap_pkg::cdap_req_t r, output logic acc);
		nxt = r;
		if (r.write && r.crm == 4'h0) begin
			nxt.wdata = r.wdata & PTR_KEEP;
		end
		pend = 1'b1;
		@(negedge clk);
		@(posedge clk);
		acc = cp_accept;
	endtask
endmodule

`default_nettype wire

// ==== cache_debug_access_port_tb.sv ====
// Self-checking bench for cdap_top at 4 KB, four ways.
// Assumes cdap_core_model drives the transfers and cdap_monitor is bound to the design.
`timescale 1ns/1ps
`default_nettype none

module cache_debug_access_port_tb;
	logic                clk = 1'b0;
	logic                arst_n = 1'b0;
	cdap_pkg::cdap_req_t cp_req;
	logic                cp_accept;
	logic                cp_rvalid;
	logic [31:0]         cp_rdata;
	logic [31:0]         eq[$];
	logic [31:0]         mq[$];
	logic [31:0]         e;
	logic [31:0]         m;
	logic [31:0]         seed = 32'h0001_5617;
	int                  num_errors = 0;
	int                  n_compared = 0;

	cdap_top #(.CACHE_KB(4), .WAYS(4)) i_dut (.CLK(clk), .ARST_N(arst_n), .CP_REQ(cp_req),
		.CP_ACCEPT(cp_accept), .CP_RVALID(cp_rvalid), .CP_RDATA(cp_rdata));
	cdap_core_model i_core (.clk(clk), .cp_accept(cp_accept), .cp_req(cp_req));

	// Clock of 8 ns.
	initial forever #4 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// A debug transfer; for reads d is the expected word and m the bits that are compared.
	task automatic op(input logic wr, input logic [3:0] crm, input logic [31:0] d, input logic [31:0] m);
		cdap_pkg::cdap_req_t r;
		logic                acc;
		r = '{1'b1, wr, 4'hF, 3'h3, 4'hF, crm, 3'h0, d};
		if (!wr) begin
			eq.push_back(d);
			mq.push_back(m);
		end
		i_core.xfer(r, acc);
		check("accept", 32'(acc), 32'h0000_0001);
	endtask

	task automatic do_reset();
		@(negedge clk) arst_n = 1'b0;
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		// Return just after a rising edge so the next request is queued before the core model's falling edge.
		repeat (2) @(negedge clk);
		@(posedge clk);
	endtask

	// Scoreboard: each answer takes the oldest note; answers stand one cycle, so look mid-cycle.
	always @(negedge clk) begin
		if (cp_rvalid === 1'b1) begin
			if (eq.size() == 0) begin
				check("unexpected answer", 32'h0000_0001, 32'h0000_0000);
			end else begin
				e = eq.pop_front();
				m = mq.pop_front();
				check("read data", cp_rdata & m, e & m);
			end
		end
	end

	// Main sequence.
	initial begin
		logic [31:0]         p;
		logic [31:0]         t;
		logic [31:0]         q [1:2];
		cdap_pkg::cdap_req_t r;
		logic                acc;
		do_reset();
		op(1'b0, 4'h0, 32'h0000_0000, 32'hFFFF_FFFF);
		for (int c = 1; c <= 2; c++) op(1'b0, 4'(c), 32'h0000_0000, 32'h0000_0010);
		for (int w = 0; w < 4; w++) begin
			for (int c = 1; c <= 2; c++) begin
				p = (rnd() & 32'h0000_03FC) | (32'(w) << 30);
				t = (rnd() & 32'hFFFF_FC0C) | (p & 32'h0000_03E0) | (32'(w != 0) << 4) | 32'(w); // Valid unless way 0.
				q[c] = p;
				op(1'b1, 4'h0, p, 32'h0);
				op(1'b0, 4'h0, p, 32'hFFFF_FFFF);
				op(1'b0, 4'h0, p, 32'hFFFF_FFFF);
				op(1'b1, 4'(c), t, 32'h0);
				op(1'b0, 4'(c), t, 32'hFFFF_FFFF);
				op(1'b1, 4'h0, p ^ 32'h0000_001C, 32'h0);
				op(1'b0, 4'(c), t, 32'hFFFF_FFFF);
			end
			p = (rnd() & 32'h0000_03F8) | (32'(w) << 30);
			t = rnd();
			op(1'b1, 4'h0, p, 32'h0);
			op(1'b1, 4'h3, t, 32'h0);
			op(1'b1, 4'h4, ~t, 32'h0);
			op(1'b0, 4'h3, t, 32'hFFFF_FFFF);
			op(1'b0, 4'h4, ~t, 32'hFFFF_FFFF);
			op(1'b1, 4'h0, p | 32'h0000_0004, 32'h0);
			op(1'b1, 4'h3, t ^ 32'h5A5A_5A5A, 32'h0);
			op(1'b0, 4'h3, t ^ 32'h5A5A_5A5A, 32'hFFFF_FFFF);
			op(1'b1, 4'h4, t ^ 32'hA5A5_A5A5, 32'h0);
			op(1'b0, 4'h4, t ^ 32'hA5A5_A5A5, 32'hFFFF_FFFF);
			op(1'b1, 4'h0, p, 32'h0);
			op(1'b0, 4'h3, t, 32'hFFFF_FFFF);
			op(1'b0, 4'h4, ~t, 32'hFFFF_FFFF);
		end
		// Transfers that miss the decode leave the pointer alone and give no answer.
		op(1'b1, 4'h0, 32'h4000_0124, 32'h0);
		for (int k = 0; k < 5; k++) begin
			r = '{1'b1, k[0], 4'hF, 3'h3, 4'hF, 4'h0, 3'h0, 32'hFFFF_FFFF};
			case (k)
				0: r.cp_num = 4'hE;
				1: r.opc1 = 3'h2;
				2: r.crn = 4'hE;
				3: r.opc2 = 3'h1;
				default: r.crm = 4'h5;
			endcase
			i_core.xfer(r, acc);
			check("refused accept", 32'(acc), 32'h0000_0000);
		end
		op(1'b0, 4'h0, 32'h4000_0124, 32'hFFFF_FFFF);
		do_reset();
		op(1'b0, 4'h0, 32'h0000_0000, 32'hFFFF_FFFF);
		for (int c = 1; c <= 2; c++) begin
			op(1'b1, 4'h0, q[c], 32'h0);
			op(1'b0, 4'(c), 32'h0000_0000, 32'h0000_0010);
		end
		repeat (2) @(negedge clk);
		check("pending answers", 32'(eq.size()), 32'h0000_0000);
		end_sim();
	end

	// The sequence needs about 140 cycles; 2500 cycles means a hang.
	initial begin
		#20000;
		num_errors++;
		end_sim();
	end
endmodule

`default_nettype wire
